// File: verilog/wpseq_pkg.sv
package wpseq_pkg;

    // Number of digital pads under control
    localparam int WPSEQ_NPADS = 8;

    // Register byte offsets
    localparam logic [7:0] WPSEQ_OFF_CTRL = 8'h00;
    localparam logic [7:0] WPSEQ_OFF_STATUS = 8'h04;
    localparam logic [7:0] WPSEQ_OFF_OE = 8'h08;
    localparam logic [7:0] WPSEQ_OFF_PULL = 8'h0c;
    localparam logic [7:0] WPSEQ_OFF_DOUT = 8'h10;
    localparam logic [7:0] WPSEQ_OFF_DIN = 8'h14;

    // Control register field positions
    localparam int WPSEQ_CTRL_CONFIGURED = 0;

    // Reset values
    localparam logic [WPSEQ_NPADS-1:0] WPSEQ_PADS_RST = 8'h00;

    // AXI responses
    localparam logic [1:0] WPSEQ_RESP_OKAY = 2'h0;
    localparam logic [1:0] WPSEQ_RESP_SLVERR = 2'h2;

    // Oscillator settle wait before reset release is honoured
    localparam int WPSEQ_CLK_MHZ = 125;
    localparam int WPSEQ_XO_SETTLE_MS = 5;
    localparam int WPSEQ_XO_SETTLE_CYC = WPSEQ_XO_SETTLE_MS * 1000 * WPSEQ_CLK_MHZ;

    // Power states, one-hot
    typedef enum logic [3:0] {
        WPSEQ_ST_CORE_OFF = 4'h1,
        WPSEQ_ST_POR = 4'h2,
        WPSEQ_ST_DEFAULT = 4'h4,
        WPSEQ_ST_PROGRAMMED = 4'h8
    } wpseq_state_e;

endpackage

// File: verilog/wpseq_top.sv
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module wpseq_top
    import wpseq_pkg::*;
#(
    parameter int XO_SETTLE_CYC = WPSEQ_XO_SETTLE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic io_supply_rail,
    input wire logic core_power_enable,
    input wire logic hard_reset_low,
    output logic dcdc_enable,
    output logic core_running,
    output logic [WPSEQ_NPADS-1:0] pad_out,
    output logic [WPSEQ_NPADS-1:0] pad_oe,
    output logic [WPSEQ_NPADS-1:0] pad_ie,
    output logic [WPSEQ_NPADS-1:0] pad_pull_en,
    input wire logic [WPSEQ_NPADS-1:0] pad_in,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // Pin synchronisers: three stages, change accepted when 2nd and 3rd agree
    // Pad inputs ride in the same synchroniser, above the three power pins
    localparam int NSYNC = WPSEQ_NPADS + 3;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    logic [NSYNC-1:0] sync3_reg;
    logic [NSYNC-1:0] pin_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= {NSYNC{1'b0}};
            sync2_reg <= {NSYNC{1'b0}};
            sync3_reg <= {NSYNC{1'b0}};
            pin_reg <= {NSYNC{1'b0}};
        end else begin
            sync1_reg <= {pad_in, io_supply_rail, core_power_enable, hard_reset_low};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            for (int i = 0; i < NSYNC; i++) begin
                if (sync2_reg[i] == sync3_reg[i]) begin
                    pin_reg[i] <= sync3_reg[i];
                end
            end
        end
    end

    logic io_on;
    logic en_on;
    logic rst_high;
    assign io_on = pin_reg[2];
    assign en_on = pin_reg[1];
    assign rst_high = pin_reg[0];
    logic [WPSEQ_NPADS-1:0] pad_in_sync;
    assign pad_in_sync = pin_reg[NSYNC-1:NSYNC-WPSEQ_NPADS];

    // Settle counter from core enable rise
    logic [31:0] settle_reg;
    logic settled;
    assign settled = (settle_reg >= 32'(XO_SETTLE_CYC));
    always_ff @(posedge aclk) begin
        if (!aresetn || !en_on) begin
            settle_reg <= 32'h0;
        end else if (!settled) begin
            settle_reg <= settle_reg + 32'h1;
        end
    end

    // Registers
    logic configured_reg;
    logic [WPSEQ_NPADS-1:0] oe_cfg_reg;
    logic [WPSEQ_NPADS-1:0] pull_cfg_reg;
    logic [WPSEQ_NPADS-1:0] dout_reg;
    wpseq_state_e state_reg;
    wpseq_state_e state_next;

    // Power state machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            WPSEQ_ST_CORE_OFF: begin
                if (io_on && en_on) begin
                    state_next = WPSEQ_ST_POR;
                end
            end
            WPSEQ_ST_POR: begin
                if (!io_on || !en_on) begin
                    state_next = WPSEQ_ST_CORE_OFF;
                end else if (rst_high && settled) begin
                    state_next = WPSEQ_ST_DEFAULT;
                end
            end
            WPSEQ_ST_DEFAULT, WPSEQ_ST_PROGRAMMED: begin
                if (!io_on || !en_on) begin
                    state_next = WPSEQ_ST_CORE_OFF;
                end else if (!rst_high) begin
                    state_next = WPSEQ_ST_POR;
                end else if (configured_reg) begin
                    state_next = WPSEQ_ST_PROGRAMMED;
                end else begin
                    state_next = WPSEQ_ST_DEFAULT;
                end
            end
            default: state_next = WPSEQ_ST_CORE_OFF;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= WPSEQ_ST_CORE_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // Pad control per state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pad_oe <= WPSEQ_PADS_RST;
            pad_ie <= WPSEQ_PADS_RST;
            pad_pull_en <= WPSEQ_PADS_RST;
            pad_out <= WPSEQ_PADS_RST;
            dcdc_enable <= 1'b0;
            core_running <= 1'b0;
        end else begin
            dcdc_enable <= en_on;
            core_running <= (state_reg == WPSEQ_ST_DEFAULT)
                || (state_reg == WPSEQ_ST_PROGRAMMED);
            pad_out <= dout_reg;
            case (state_reg)
                WPSEQ_ST_POR: begin
                    pad_oe <= WPSEQ_PADS_RST;
                    pad_ie <= WPSEQ_PADS_RST;
                    pad_pull_en <= ~WPSEQ_PADS_RST;
                end
                WPSEQ_ST_DEFAULT: begin
                    pad_oe <= WPSEQ_PADS_RST;
                    pad_ie <= ~WPSEQ_PADS_RST;
                    pad_pull_en <= ~WPSEQ_PADS_RST;
                end
                WPSEQ_ST_PROGRAMMED: begin
                    pad_oe <= oe_cfg_reg;
                    pad_ie <= ~oe_cfg_reg;
                    pad_pull_en <= pull_cfg_reg;
                end
                default: begin
                    pad_oe <= WPSEQ_PADS_RST;
                    pad_ie <= WPSEQ_PADS_RST;
                    pad_pull_en <= WPSEQ_PADS_RST;
                end
            endcase
        end
    end

    // AXI4-Lite write channel
    logic [7:0] awaddr_reg;
    logic aw_have_reg;
    logic [31:0] wdata_reg;
    logic w_have_reg;
    logic wstrb0_reg;
    logic do_write;
    assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == WPSEQ_OFF_CTRL) || (a == WPSEQ_OFF_STATUS)
            || (a == WPSEQ_OFF_OE) || (a == WPSEQ_OFF_PULL)
            || (a == WPSEQ_OFF_DOUT) || (a == WPSEQ_OFF_DIN);
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            wstrb0_reg <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= WPSEQ_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have_reg && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_have_reg && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_known(awaddr_reg) ? WPSEQ_RESP_OKAY : WPSEQ_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Configuration registers; cleared whenever the core leaves running state
    always_ff @(posedge aclk) begin
        if (!aresetn || !core_running) begin
            configured_reg <= 1'b0;
            oe_cfg_reg <= WPSEQ_PADS_RST;
            pull_cfg_reg <= WPSEQ_PADS_RST;
            dout_reg <= WPSEQ_PADS_RST;
        end else if (do_write && wstrb0_reg) begin
            case (awaddr_reg)
                WPSEQ_OFF_CTRL: configured_reg <= wdata_reg[WPSEQ_CTRL_CONFIGURED];
                WPSEQ_OFF_OE: oe_cfg_reg <= wdata_reg[WPSEQ_NPADS-1:0];
                WPSEQ_OFF_PULL: pull_cfg_reg <= wdata_reg[WPSEQ_NPADS-1:0];
                WPSEQ_OFF_DOUT: dout_reg <= wdata_reg[WPSEQ_NPADS-1:0];
                default: ;
            endcase
        end
    end

    // AXI4-Lite read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= WPSEQ_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= addr_known(s_axi_araddr) ? WPSEQ_RESP_OKAY : WPSEQ_RESP_SLVERR;
                case (s_axi_araddr)
                    WPSEQ_OFF_CTRL: s_axi_rdata <= 32'(configured_reg);
                    WPSEQ_OFF_STATUS: s_axi_rdata <= 32'({settled, io_on, en_on, rst_high,
                        state_reg});
                    WPSEQ_OFF_OE: s_axi_rdata <= 32'(oe_cfg_reg);
                    WPSEQ_OFF_PULL: s_axi_rdata <= 32'(pull_cfg_reg);
                    WPSEQ_OFF_DOUT: s_axi_rdata <= 32'(dout_reg);
                    WPSEQ_OFF_DIN: s_axi_rdata <= 32'(pad_in_sync & pad_ie);
                    default: s_axi_rdata <= 32'h0;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// File: dv/wpseq_properties.sv
`timescale 1ns/10ps
module wpseq_properties
    import wpseq_pkg::*;
#(
    parameter int XO_SETTLE_CYC = 20
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic core_power_enable,
    input wire logic dcdc_enable,
    input wire logic core_running,
    input wire logic [WPSEQ_NPADS-1:0] pad_oe,
    input wire logic [WPSEQ_NPADS-1:0] pad_ie,
    input wire logic [WPSEQ_NPADS-1:0] pad_pull_en
);
    int on_cnt;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    always_ff @(posedge aclk) begin
        if (!aresetn || !dcdc_enable) on_cnt <= 0;
        else if (on_cnt < XO_SETTLE_CYC) on_cnt <= on_cnt + 1;
    end
    a_off_quiet: assert property (
        !dcdc_enable && !$past(dcdc_enable) && !$past(dcdc_enable, 2)
        |-> pad_oe == '0 && pad_ie == '0 && pad_pull_en == '0) else $error("pads on in core off");
    a_oe_running: assert property (
        pad_oe != '0 |-> core_running || $past(core_running)) else $error("drive while idle");
    a_ie_opposite: assert property (
        pad_oe != '0 && core_running |-> pad_ie == ~pad_oe) else $error("ie not opposite oe");
    a_default_inputs: assert property (
        core_running && $past(core_running, 2) && pad_oe == '0 |-> pad_ie == 8'hff)
        else $error("inputs off when running");
    a_pull_entry: assert property (
        $rose(core_running) |-> pad_pull_en == 8'hff && pad_oe == '0) else $error("bad entry pads");
    a_dcdc_on: assert property (
        $rose(core_power_enable) |-> ##[1:6] dcdc_enable) else $error("converter not on");
    a_run_dcdc: assert property (
        core_running |-> dcdc_enable || $past(dcdc_enable)) else $error("running without core");
    a_settle_wait: assert property (
        $rose(core_running) |-> on_cnt >= XO_SETTLE_CYC - 2) else $error("settle too short");
    c_run: cover property ($rose(core_running));
    c_prog: cover property (core_running && pad_oe != '0);
    c_down: cover property ($fell(dcdc_enable));
endmodule
bind wpseq_top wpseq_properties #(.XO_SETTLE_CYC(XO_SETTLE_CYC)) u_props (
    .aclk(aclk), .aresetn(aresetn), .core_power_enable(core_power_enable),
    .dcdc_enable(dcdc_enable), .core_running(core_running), .pad_oe(pad_oe),
    .pad_ie(pad_ie), .pad_pull_en(pad_pull_en));

// File: dv/wpseq_host_model.sv
`timescale 1ns/10ps
module wpseq_host_model #(
    parameter int HOLD = 30
) (
    input wire logic aclk,
    input wire logic power_up,
    input wire logic hold_rst,
    output logic io_supply_rail = 1'b0,
    output logic core_power_enable = 1'b0,
    output logic hard_reset_low = 1'b0
);
    int cnt = 0;
    always @(posedge aclk) begin
        if (power_up) begin
            io_supply_rail <= 1'b1;
            if (io_supply_rail) core_power_enable <= 1'b1;
            if (core_power_enable && cnt < HOLD) cnt <= cnt + 1;
            hard_reset_low <= cnt >= HOLD && !hold_rst;
        end else begin
            core_power_enable <= 1'b0;
            hard_reset_low <= 1'b0;
            cnt <= 0;
            if (!core_power_enable && !hard_reset_low) io_supply_rail <= 1'b0;
        end
    end
endmodule

// File: dv/test_wireless_module_power_sequencing.sv
`timescale 1ns/10ps
module test_wireless_module_power_sequencing
    import wpseq_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, up = 1'b0, hr = 1'b0, rail, en, rstn, dcdc, run;
    logic [7:0] pout, oe, ie, pull, pin = 8'ha5, awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    int miscompares = 0, checks = 0;
    always #4 aclk = ~aclk;
    wpseq_host_model host (.aclk(aclk), .power_up(up), .hold_rst(hr),
        .io_supply_rail(rail), .core_power_enable(en), .hard_reset_low(rstn));
    wpseq_top #(.XO_SETTLE_CYC(20)) uut (.aclk(aclk), .aresetn(aresetn),
        .io_supply_rail(rail), .core_power_enable(en), .hard_reset_low(rstn),
        .dcdc_enable(dcdc), .core_running(run), .pad_out(pout), .pad_oe(oe), .pad_ie(ie),
        .pad_pull_en(pull), .pad_in(pin), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    task automatic print_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 100) begin
            $display("ERROR t=%0t wait timed out", $time);
            miscompares++;
            print_verdict();
        end
    endtask
    task automatic pads(input logic [7:0] o, input logic [7:0] i, input logic [7:0] p);
        int n;
        for (n = 0; n < 100 && {oe, ie, pull} !== {o, i, p}; n++) @(negedge aclk);
        tmo(n);
        chk({8'h0, oe, ie, pull}, {8'h0, o, i, p});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        tmo(n);
        chk({30'h0, bresp}, {30'h0, e});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        tmo(n);
        chk({rdata[29:0], rresp}, {d[29:0], e});
    endtask
    task automatic t_off;
        pads(8'h0, 8'h0, 8'h0);
        chk({31'h0, dcdc}, 32'h0);
        rd(WPSEQ_OFF_STATUS, 32'h1, WPSEQ_RESP_OKAY);
        wr(WPSEQ_OFF_OE, 32'hff, WPSEQ_RESP_OKAY);
        rd(WPSEQ_OFF_OE, 32'h0, WPSEQ_RESP_OKAY);
        rd(8'h40, 32'h0, WPSEQ_RESP_SLVERR);
        $display("test core off done");
    endtask
    task automatic t_up;
        @(posedge aclk);
        up <= 1'b1;
        pads(8'h0, 8'h0, 8'hff);
        chk({31'h0, dcdc}, 32'h1);
        pads(8'h0, 8'hff, 8'hff);
        chk({30'h0, dcdc, run}, 32'h3);
        rd(WPSEQ_OFF_STATUS, 32'hf4, WPSEQ_RESP_OKAY);
        rd(WPSEQ_OFF_DIN, 32'ha5, WPSEQ_RESP_OKAY);
        $display("test power up done");
    endtask
    task automatic t_prog;
        wr(WPSEQ_OFF_OE, 32'h0f, WPSEQ_RESP_OKAY);
        wr(WPSEQ_OFF_PULL, 32'h33, WPSEQ_RESP_OKAY);
        wr(WPSEQ_OFF_DOUT, 32'h5a, WPSEQ_RESP_OKAY);
        wr(8'h40, 32'h1, WPSEQ_RESP_SLVERR);
        pads(8'h0, 8'hff, 8'hff);
        wr(WPSEQ_OFF_CTRL, 32'h1, WPSEQ_RESP_OKAY);
        pads(8'h0f, 8'hf0, 8'h33);
        chk({24'h0, pout}, 32'h5a);
        rd(WPSEQ_OFF_DIN, 32'ha0, WPSEQ_RESP_OKAY);
        rd(WPSEQ_OFF_STATUS, 32'hf8, WPSEQ_RESP_OKAY);
        $display("test programmed done");
    endtask
    task automatic t_again;
        @(posedge aclk);
        hr <= 1'b1;
        pads(8'h0, 8'h0, 8'hff);
        @(posedge aclk);
        hr <= 1'b0;
        pads(8'h0, 8'hff, 8'hff);
        rd(WPSEQ_OFF_OE, 32'h0, WPSEQ_RESP_OKAY);
        @(posedge aclk);
        up <= 1'b0;
        pads(8'h0, 8'h0, 8'h0);
        chk({31'h0, dcdc, run}, 32'h0);
        $display("test reset and power down done");
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_off();
        t_up();
        t_prog();
        t_again();
        print_verdict();
    end
endmodule
